// File: pdsc_params.svh
// register offsets, field positions, reset values for the phy diagnostic register group
`ifndef PDSC_PARAMS_SVH
`define PDSC_PARAMS_SVH

// register indices on the management port
`define PDSC_FE_STATUS_IDX 5'h10
`define PDSC_GE_STATUS_IDX 5'h11
`define PDSC_BYPASS_IDX 5'h12
`define PDSC_RXERR_CNT_IDX 5'h13
`define PDSC_FCAR_CNT_IDX 5'h14
`define PDSC_LDROP_CNT_IDX 5'h15
`define PDSC_IRQ_STATUS_IDX 5'h1C
`define PDSC_IRQ_MASK_IDX 5'h1D

// live bit positions: locked and link in both status registers, legacy and mdix error in the gigabit one only
`define PDSC_ST_LOCKED_BIT 15
`define PDSC_ST_LINK_BIT 12
`define PDSC_ST_LEGACY_BIT 6
`define PDSC_ST_MDIX_ERR_BIT 5

// sticky event bit positions, shared by both status registers except carrier extension (gigabit only)
`define PDSC_ST_LOCK_ERR_BIT 14
`define PDSC_ST_DISC_BIT 13
`define PDSC_ST_RX_ERR_BIT 11
`define PDSC_ST_TX_ERR_BIT 10
`define PDSC_ST_SSD_ERR_BIT 9
`define PDSC_ST_ESD_ERR_BIT 8
`define PDSC_ST_CEXT_ERR_BIT 7

// sticky event bits: fast ethernet 14,13,11,10,9,8; gigabit adds 7
`define PDSC_FE_STICKY_MASK 16'h6F00
`define PDSC_GE_STICKY_MASK 16'h6F80

// bypass control register
`define PDSC_BYP_TX_OFF_BIT 15
`define PDSC_BYP_CODER_BIT 14
`define PDSC_BYP_SCRAMBLER_BIT 13
`define PDSC_BYP_DESCRAMBLER_BIT 12
`define PDSC_BYP_PCS_RX_BIT 11
`define PDSC_BYP_PCS_TX_BIT 10
`define PDSC_BYP_LEGACY_DET_BIT 6
`define PDSC_BYP_MDIX_CORR_BIT 5
`define PDSC_BYP_LFI_TIMER_BIT 9
`define PDSC_BYP_FORCED_MDIX_BIT 7
`define PDSC_BYP_POLARITY_BIT 4
`define PDSC_BYP_ADV_ABILITY_BIT 3
`define PDSC_BYP_PULSE_FILTER_BIT 2
`define PDSC_BYP_NEXT_PAGE_BIT 1
`define PDSC_BYP_WRITE_MASK 16'hFEFE
`define PDSC_BYP_RESET 16'h0088

// interrupt status / mask layout
`define PDSC_IRQ_FE_BIT 0
`define PDSC_IRQ_GE_BIT 1
`define PDSC_IRQ_DROP_BIT 2
`define PDSC_IRQ_SAT_BIT 3
`define PDSC_IRQ_W 4

// counters
`define PDSC_CNT_W 8
`define PDSC_CNT_MAX 8'hFF

`endif

// File: pdsc_pkg.sv
// types for the phy diagnostic register group
package pdsc_pkg;
`include "pdsc_params.svh"

   typedef logic [`PDSC_CNT_W-1:0] pdsc_cnt_t;

   typedef struct packed {
      logic [15:0] feSticky;
      logic [15:0] geSticky;
      logic [15:0] bypass;
      pdsc_cnt_t rxErrCnt;
      pdsc_cnt_t falseCarCnt;
      pdsc_cnt_t linkDropCnt;
      logic [`PDSC_IRQ_W-1:0] irqStatus;
      logic [`PDSC_IRQ_W-1:0] irqMask;
      logic irq;
      logic [15:0] rdData;
   } pdsc_state_t;
endpackage

// File: pdsc_regs.sv
// diagnostic status, bypass control and event counter registers of the phy
//
// The strobed register port was decided locally.
`timescale 1ns/100ps

`include "pdsc_params.svh"

module pdsc_regs
   import pdsc_pkg::*;
#(
   parameter int ADDR_W = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // management register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [15:0] regRdData,
   // fast ethernet receive path: live state and event pulses
   input wire logic feLocked,
   input wire logic feLinkUp,
   input wire logic feLockErr,
   input wire logic feDisconnect,
   input wire logic feRxErr,
   input wire logic feTxErr,
   input wire logic feSsdErr,
   input wire logic feEsdErr,
   input wire logic feFalseCarrier,
   // gigabit receive path: live state and event pulses
   input wire logic geLocked,
   input wire logic geLinkUp,
   input wire logic geLockErr,
   input wire logic geDisconnect,
   input wire logic geRxErr,
   input wire logic geTxErr,
   input wire logic geSsdErr,
   input wire logic geEsdErr,
   input wire logic geCarrierExtErr,
   input wire logic geFalseCarrier,
   input wire logic legacyPartner,
   input wire logic mdixErr,
   // any copper link drop, any speed
   input wire logic linkDrop,
   // datapath controls
   output logic txOutputOff,
   output logic bypassCoder,
   output logic bypassScrambler,
   output logic bypassDescrambler,
   output logic bypassPcsRx,
   output logic bypassPcsTx,
   output logic skipLinkFailTimer,
   output logic noAutoMdixForced,
   output logic legacyDetectOff,
   output logic noMdixCorrection,
   output logic noPolarityCorrection,
   output logic honourAdvAbility,
   output logic pulseFilterOff,
   output logic gigNextPageOff,
   // interrupt
   output logic irq
);

   // the decoder takes the low five bits as the register index
   if (ADDR_W < 5) begin : gAddrWidthCheck
      $error("pdsc_regs: ADDR_W must be at least 5");
   end

   pdsc_state_t s_q;
   pdsc_state_t s_d;

   // saturating add of up to two hits
   function automatic pdsc_cnt_t satAdd(input pdsc_cnt_t cnt, input logic [1:0] hits);
      logic [`PDSC_CNT_W:0] sum;
      sum = {1'b0, cnt} + {{(`PDSC_CNT_W-1){1'b0}}, hits};
      if (sum[`PDSC_CNT_W]) begin
         satAdd = `PDSC_CNT_MAX;
      end else begin
         satAdd = sum[`PDSC_CNT_W-1:0];
      end
   endfunction

   // next count: a read restarts from the hits of this very cycle
   function automatic pdsc_cnt_t cntNext(input pdsc_cnt_t cnt, input logic rd,
                                         input logic [1:0] hits);
      if (rd) begin
         cntNext = satAdd('0, hits);
      end else begin
         cntNext = satAdd(cnt, hits);
      end
   endfunction

   function automatic logic isAddr(input logic [ADDR_W-1:0] a, input logic [4:0] idx);
      isAddr = (a == ADDR_W'(idx));
   endfunction

   // both speeds share one counter; each event counts only while its own link is up
   function automatic logic [1:0] linkHits(
      input logic feEv,
      input logic feUp,
      input logic geEv,
      input logic geUp
   );
      logic [1:0] feHit;
      logic [1:0] geHit;
      feHit = {1'b0, feEv & feUp};
      geHit = {1'b0, geEv & geUp};
      linkHits = feHit + geHit;
   endfunction

   // only the step onto the ceiling counts, so a parked counter raises one event
   function automatic logic reachedMax(
      input pdsc_cnt_t prevCnt,
      input pdsc_cnt_t nextCnt
   );
      reachedMax = (nextCnt == `PDSC_CNT_MAX) && (prevCnt != `PDSC_CNT_MAX);
   endfunction

   // counters sit in the low byte, the upper byte is reserved
   function automatic logic [15:0] cntView(input pdsc_cnt_t cnt);
      cntView = {{(16-`PDSC_CNT_W){1'b0}}, cnt};
   endfunction

   function automatic logic [15:0] irqView(input logic [`PDSC_IRQ_W-1:0] flags);
      irqView = {{(16-`PDSC_IRQ_W){1'b0}}, flags};
   endfunction

   logic [15:0] feEvents;
   logic [15:0] geEvents;
   logic [15:0] feView;
   logic [15:0] geView;
   logic [1:0] rxErrHits;
   logic [1:0] fcarHits;
   logic [1:0] dropHits;
   logic rdFe;
   logic rdGe;
   logic rdRx;
   logic rdFc;
   logic rdLd;
   logic [`PDSC_IRQ_W-1:0] irqEvents;

   always_comb begin
      s_d = s_q;

      // event positions, same bit order in both status registers
      feEvents = 16'h0000;
      feEvents[`PDSC_ST_LOCK_ERR_BIT] = feLockErr;
      feEvents[`PDSC_ST_DISC_BIT] = feDisconnect;
      feEvents[`PDSC_ST_RX_ERR_BIT] = feRxErr;
      feEvents[`PDSC_ST_TX_ERR_BIT] = feTxErr;
      feEvents[`PDSC_ST_SSD_ERR_BIT] = feSsdErr;
      feEvents[`PDSC_ST_ESD_ERR_BIT] = feEsdErr;
      geEvents = 16'h0000;
      geEvents[`PDSC_ST_LOCK_ERR_BIT] = geLockErr;
      geEvents[`PDSC_ST_DISC_BIT] = geDisconnect;
      geEvents[`PDSC_ST_RX_ERR_BIT] = geRxErr;
      geEvents[`PDSC_ST_TX_ERR_BIT] = geTxErr;
      geEvents[`PDSC_ST_SSD_ERR_BIT] = geSsdErr;
      geEvents[`PDSC_ST_ESD_ERR_BIT] = geEsdErr;
      geEvents[`PDSC_ST_CEXT_ERR_BIT] = geCarrierExtErr;

      // live bits are read straight from the datapath, never stored
      feView = s_q.feSticky & `PDSC_FE_STICKY_MASK;
      feView[`PDSC_ST_LOCKED_BIT] = feLocked;
      feView[`PDSC_ST_LINK_BIT] = feLinkUp;
      geView = s_q.geSticky & `PDSC_GE_STICKY_MASK;
      geView[`PDSC_ST_LOCKED_BIT] = geLocked;
      geView[`PDSC_ST_LINK_BIT] = geLinkUp;
      geView[`PDSC_ST_LEGACY_BIT] = legacyPartner;
      geView[`PDSC_ST_MDIX_ERR_BIT] = mdixErr;

      rdFe = regRdStb && isAddr(regAddr, `PDSC_FE_STATUS_IDX);
      rdGe = regRdStb && isAddr(regAddr, `PDSC_GE_STATUS_IDX);
      rdRx = regRdStb && isAddr(regAddr, `PDSC_RXERR_CNT_IDX);
      rdFc = regRdStb && isAddr(regAddr, `PDSC_FCAR_CNT_IDX);
      rdLd = regRdStb && isAddr(regAddr, `PDSC_LDROP_CNT_IDX);

      // sticky bits: event wins over the clear of the same cycle
      s_d.feSticky = ((rdFe ? 16'h0000 : s_q.feSticky) | feEvents)
                     & `PDSC_FE_STICKY_MASK;
      s_d.geSticky = ((rdGe ? 16'h0000 : s_q.geSticky) | geEvents)
                     & `PDSC_GE_STICKY_MASK;

      // receive errors and false carriers counted only while the matching link is up, link drops always
      rxErrHits = linkHits(feRxErr, feLinkUp, geRxErr, geLinkUp);
      fcarHits = linkHits(feFalseCarrier, feLinkUp, geFalseCarrier, geLinkUp);
      dropHits = {1'b0, linkDrop};
      s_d.rxErrCnt = cntNext(s_q.rxErrCnt, rdRx, rxErrHits);
      s_d.falseCarCnt = cntNext(s_q.falseCarCnt, rdFc, fcarHits);
      s_d.linkDropCnt = cntNext(s_q.linkDropCnt, rdLd, dropHits);

      // register writes
      if (regWrStb) begin
         if (isAddr(regAddr, `PDSC_BYPASS_IDX)) begin
            s_d.bypass = regWrData & `PDSC_BYP_WRITE_MASK;
         end
         if (isAddr(regAddr, `PDSC_IRQ_MASK_IDX)) begin
            s_d.irqMask = regWrData[`PDSC_IRQ_W-1:0];
         end
      end

      // interrupt status: write one to clear, new event wins
      irqEvents = '0;
      irqEvents[`PDSC_IRQ_FE_BIT] = |feEvents;
      irqEvents[`PDSC_IRQ_GE_BIT] = |geEvents;
      irqEvents[`PDSC_IRQ_DROP_BIT] = linkDrop;
      irqEvents[`PDSC_IRQ_SAT_BIT] = reachedMax(s_q.rxErrCnt, s_d.rxErrCnt)
                                     || reachedMax(s_q.falseCarCnt, s_d.falseCarCnt)
                                     || reachedMax(s_q.linkDropCnt, s_d.linkDropCnt);
      if (regWrStb && isAddr(regAddr, `PDSC_IRQ_STATUS_IDX)) begin
         s_d.irqStatus = s_q.irqStatus & ~regWrData[`PDSC_IRQ_W-1:0];
      end
      s_d.irqStatus = s_d.irqStatus | irqEvents;
      s_d.irq = |(s_d.irqStatus & s_d.irqMask);

      // read data valid the cycle after the strobe only
      s_d.rdData = 16'h0000;
      if (regRdStb) begin
         case (regAddr[4:0])
            `PDSC_FE_STATUS_IDX: begin
               s_d.rdData = feView;
            end
            `PDSC_GE_STATUS_IDX: begin
               s_d.rdData = geView;
            end
            `PDSC_BYPASS_IDX: begin
               s_d.rdData = s_q.bypass;
            end
            `PDSC_RXERR_CNT_IDX: begin
               s_d.rdData = cntView(s_q.rxErrCnt);
            end
            `PDSC_FCAR_CNT_IDX: begin
               s_d.rdData = cntView(s_q.falseCarCnt);
            end
            `PDSC_LDROP_CNT_IDX: begin
               s_d.rdData = cntView(s_q.linkDropCnt);
            end
            `PDSC_IRQ_STATUS_IDX: begin
               s_d.rdData = irqView(s_q.irqStatus);
            end
            `PDSC_IRQ_MASK_IDX: begin
               s_d.rdData = irqView(s_q.irqMask);
            end
            default: begin
               s_d.rdData = 16'h0000;
            end
         endcase
         // upper address bits must be zero for any hit
         if (ADDR_W > 5 && !isAddr(regAddr, regAddr[4:0])) begin
            s_d.rdData = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q.feSticky <= 16'h0000;
         s_q.geSticky <= 16'h0000;
         s_q.bypass <= `PDSC_BYP_RESET;
         s_q.rxErrCnt <= '0;
         s_q.falseCarCnt <= '0;
         s_q.linkDropCnt <= '0;
         s_q.irqStatus <= '0;
         s_q.irqMask <= '0;
         s_q.irq <= 1'b0;
         s_q.rdData <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign regRdData = s_q.rdData;
   assign irq = s_q.irq;
   assign txOutputOff = s_q.bypass[`PDSC_BYP_TX_OFF_BIT];
   assign bypassCoder = s_q.bypass[`PDSC_BYP_CODER_BIT];
   assign bypassScrambler = s_q.bypass[`PDSC_BYP_SCRAMBLER_BIT];
   assign bypassDescrambler = s_q.bypass[`PDSC_BYP_DESCRAMBLER_BIT];
   assign bypassPcsRx = s_q.bypass[`PDSC_BYP_PCS_RX_BIT];
   assign bypassPcsTx = s_q.bypass[`PDSC_BYP_PCS_TX_BIT];
   assign skipLinkFailTimer = s_q.bypass[`PDSC_BYP_LFI_TIMER_BIT];
   assign noAutoMdixForced = s_q.bypass[`PDSC_BYP_FORCED_MDIX_BIT];
   assign legacyDetectOff = s_q.bypass[`PDSC_BYP_LEGACY_DET_BIT];
   assign noMdixCorrection = s_q.bypass[`PDSC_BYP_MDIX_CORR_BIT];
   assign noPolarityCorrection = s_q.bypass[`PDSC_BYP_POLARITY_BIT];
   assign honourAdvAbility = s_q.bypass[`PDSC_BYP_ADV_ABILITY_BIT];
   assign pulseFilterOff = s_q.bypass[`PDSC_BYP_PULSE_FILTER_BIT];
   assign gigNextPageOff = s_q.bypass[`PDSC_BYP_NEXT_PAGE_BIT];

endmodule // pdsc_regs

// File: pdsc_regs_props.sv
// concurrent checks on the ports of the diagnostic register group
`timescale 1ns/100ps
module pdsc_regs_props #(
   parameter int ADDR_W = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [15:0] regRdData,
   // events and controls
   input wire logic feLocked,
   input wire logic feLinkUp,
   input wire logic feRxErr,
   input wire logic geLinkUp,
   input wire logic geRxErr,
   input wire logic txOutputOff,
   input wire logic honourAdvAbility,
   input wire logic irq
);
   wire logic rd10 = regRdStb && regAddr == 5'h10;
   wire logic rd13 = regRdStb && regAddr == 5'h13;
   wire logic rxHit = (feRxErr && feLinkUp) || (geRxErr && geLinkUp);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_rd_idle_zero: assert property (!regRdStb |=> regRdData == 16'h0000)
      else $error("read data not zero outside a read");
   a_byp_write: assert property (regWrStb && regAddr == 5'h12 |=>
      txOutputOff == $past(regWrData[15]) && honourAdvAbility == $past(regWrData[3]))
      else $error("bypass write not reflected on controls");
   a_reset_dflt: assert property (disable iff (1'b0) !rst_b |=>
      honourAdvAbility && !txOutputOff && !irq && regRdData == 16'h0000)
      else $error("reset values wrong");
   a_live_lock: assert property (rd10 |=> regRdData[15] == $past(feLocked)
      && regRdData[12] == $past(feLinkUp)) else $error("live bits wrong");
   a_fe_sticky: assert property (feRxErr ##1 rd10 |=> regRdData[11])
      else $error("sticky receive error lost");
   a_fe_clear: assert property (rd10 && !feRxErr ##1 rd10 |=> !regRdData[11])
      else $error("sticky bit not cleared by read");
   a_cnt_clear: assert property (rd13 && !rxHit ##1 rd13 |=> regRdData == 16'h0000)
      else $error("counter not cleared by read");
   a_cnt_race: assert property (rd13 && feRxErr && feLinkUp && !(geRxErr && geLinkUp)
      ##1 rd13 |=> regRdData == 16'h0001) else $error("event lost to read clear");
   a_rsvd_zero: assert property (rd13 |=> regRdData[15:8] == 8'h00)
      else $error("reserved counter bits set");
endmodule // pdsc_regs_props

bind pdsc_regs pdsc_regs_props #(.ADDR_W(ADDR_W)) props_u (.clk(clk), .rst_b(rst_b),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData(regRdData), .feLocked(feLocked), .feLinkUp(feLinkUp), .feRxErr(feRxErr),
   .geLinkUp(geLinkUp), .geRxErr(geRxErr), .txOutputOff(txOutputOff),
   .honourAdvAbility(honourAdvAbility), .irq(irq));

// File: pdsc_regs_test.sv
// self-checking bench with a cycle model of the diagnostic register group
`timescale 1ns/100ps
`include "pdsc_params.svh"
module pdsc_regs_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic [21:0] ev = 22'h000000;
   logic [15:0] regRdData, fS, gS, byp, expRd, feSet, geSet;
   logic [13:0] ctl;
   logic irq, pend, eIrq1;
   logic [3:0] ist, msk;
   int rx, fc, ld, errors, total_checks, i;

   pdsc_regs dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .feLocked(ev[0]), .feLinkUp(ev[1]), .feEsdErr(ev[2]), .feSsdErr(ev[3]),
      .feTxErr(ev[4]), .feRxErr(ev[5]), .feDisconnect(ev[6]), .feLockErr(ev[7]),
      .feFalseCarrier(ev[8]), .geLocked(ev[9]), .geLinkUp(ev[10]),
      .geCarrierExtErr(ev[11]), .geEsdErr(ev[12]), .geSsdErr(ev[13]), .geTxErr(ev[14]),
      .geRxErr(ev[15]), .geDisconnect(ev[16]), .geLockErr(ev[17]),
      .geFalseCarrier(ev[18]), .legacyPartner(ev[19]), .mdixErr(ev[20]),
      .linkDrop(ev[21]), .txOutputOff(ctl[13]), .bypassCoder(ctl[12]),
      .bypassScrambler(ctl[11]), .bypassDescrambler(ctl[10]), .bypassPcsRx(ctl[9]),
      .bypassPcsTx(ctl[8]), .skipLinkFailTimer(ctl[7]), .noAutoMdixForced(ctl[6]),
      .legacyDetectOff(ctl[5]), .noMdixCorrection(ctl[4]), .noPolarityCorrection(ctl[3]),
      .honourAdvAbility(ctl[2]), .pulseFilterOff(ctl[1]), .gigNextPageOff(ctl[0]),
      .irq(irq));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic int sat(input int v);
      return v > 255 ? 255 : v;
   endfunction

   // one clock of the model; inputs seen at this edge are those sampled by the design
   task automatic cyc(input int op, input logic [4:0] a, input logic [15:0] d,
      input logic [21:0] nev);
      logic rd;
      int rxOld, fcOld, ldOld;
      @(posedge clk);
      rd = regRdStb;
      if (rst_b) begin
         if (pend) chk("regRdData", expRd, regRdData);
         chk("controls", {2'b00, byp[15:9], byp[7:1]}, {2'b00, ctl});
         chk("irq", {15'h0000, eIrq1}, {15'h0000, irq});
      end
      pend = rd;
      case (regAddr)
         5'h10: expRd = fS | {ev[0], 2'b00, ev[1], 12'h000};
         5'h11: expRd = gS | {ev[9], 2'b00, ev[10], 5'h00, ev[19], ev[20], 5'h00};
         5'h12: expRd = byp;
         5'h13: expRd = 16'(rx);
         5'h14: expRd = 16'(fc);
         5'h15: expRd = 16'(ld);
         5'h1C: expRd = {12'h000, ist};
         5'h1D: expRd = {12'h000, msk};
         default: expRd = 16'h0000;
      endcase
      feSet = {1'b0, ev[7:6], 1'b0, ev[5:2], 8'h00};
      geSet = {1'b0, ev[17:16], 1'b0, ev[15:11], 7'h00};
      if (rd && regAddr == 5'h10) fS = 16'h0000;
      if (rd && regAddr == 5'h11) gS = 16'h0000;
      fS |= feSet;
      gS |= geSet;
      rxOld = rx;
      fcOld = fc;
      ldOld = ld;
      // a read restarts from this cycle's hits, so no event is lost
      rx = (rd && regAddr == 5'h13 ? 0 : rx) + (ev[5] & ev[1]) + (ev[15] & ev[10]);
      fc = (rd && regAddr == 5'h14 ? 0 : fc) + (ev[8] & ev[1]) + (ev[18] & ev[10]);
      ld = (rd && regAddr == 5'h15 ? 0 : ld) + ev[21];
      rx = sat(rx);
      fc = sat(fc);
      ld = sat(ld);
      if (regWrStb && regAddr == 5'h1C) ist &= ~regWrData[3:0];
      // the saturation flag is raised by the step onto 255, not by staying there
      ist |= {(rx == 255 && rxOld != 255) || (fc == 255 && fcOld != 255)
         || (ld == 255 && ldOld != 255), ev[21], |geSet, |feSet};
      if (regWrStb && regAddr == 5'h1D) msk = regWrData[3:0];
      if (regWrStb && regAddr == 5'h12) byp = regWrData & `PDSC_BYP_WRITE_MASK;
      eIrq1 = |(ist & msk);
      if (!rst_b) begin
         {fS, gS, ist, msk, rx, fc, ld, pend, eIrq1} = '0;
         byp = `PDSC_BYP_RESET;
      end
      regRdStb <= (op == 1);
      regWrStb <= (op == 2);
      regAddr <= a;
      regWrData <= d;
      ev <= nev;
   endtask

   task wrap_up;
      if (errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      errors = 0;
      total_checks = 0;
      void'($urandom(77414));
      for (i = 0; i < 10; i++) cyc(0, 5'h00, 16'h0000, 22'h000000);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i++) cyc(1, 5'h10 + i[4:0], 16'h0000, 22'h000000);
      // sparse events, links toggling, random reads and writes anywhere
      for (i = 0; i < 3000; i++) cyc($urandom % 4, 5'h10 + 5'($urandom % 16),
         16'($urandom), 22'($urandom & $urandom & $urandom) | ((i & 256) ? 22'h402 : 22'h0));
      // reset again from a random state: controls must return to their defaults
      rst_b <= 1'b0;
      for (i = 0; i < 2; i++) cyc(0, 5'h00, 16'h0000, 22'h000000);
      rst_b <= 1'b1;
      // dense events without reads drive every counter into saturation
      for (i = 0; i < 600; i++) cyc(0, 5'h00, 16'h0000, 22'($urandom) | 22'h000402);
      for (i = 0; i < 96; i++) cyc(1, 5'h10 + 5'((i / 2) % 6), 16'h0000,
         22'($urandom & $urandom & $urandom) | 22'h000402);
      // directed: sticky bit read then cleared, and a counter read meeting a hit
      cyc(0, 5'h00, 16'h0000, 22'h000020);
      cyc(1, 5'h10, 16'h0000, 22'h000000);
      cyc(1, 5'h10, 16'h0000, 22'h000000);
      cyc(1, 5'h13, 16'h0000, 22'h000022);
      cyc(1, 5'h13, 16'h0000, 22'h000000);
      cyc(0, 5'h00, 16'h0000, 22'h000000);
      cyc(0, 5'h00, 16'h0000, 22'h000000);
      wrap_up();
   end
endmodule // pdsc_regs_test
